/* sim/mcs_link_host.sv */
/*
 * Behavioural serial host that sends channel choice frames on the link.
 * Assumes the bench calls send() and that the clock stands still between
 * frames, as a real host would leave it.
 */
module mcs_link_host (
   output logic link_clk_out,
   output logic link_sel_n_out,
   output logic link_sdi_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle: clock parked low, frame deselected
   initial begin
      link_clk_out = 1'b0;
      link_sel_n_out = 1'b1;
      link_sdi_out = 1'b0;
   end

   // Five bits, MSB first, data set while the clock is low
   task automatic send(input logic [4:0] word);
      #13 link_sel_n_out = 1'b0; // Odd offset keeps phase unrelated
      for (int i = 4; i >= 0; i--) begin
         link_sdi_out = word[i];
         #32 link_clk_out = 1'b1;
         #32 link_clk_out = 1'b0;
      end
      #20 link_sel_n_out = 1'b1;
      link_sdi_out = ~link_sdi_out; // Released line shows no stale bit
      #200;
   endtask
endmodule // mcs_link_host

/* sim/mux_channel_sequencer_ctrl_test.sv */
/*
 * Self-checking bench for the sequencer control registers.
 * Assumes the link host model stands on the serial side.
 */
module mux_channel_sequencer_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   import mcs_pkg::*;

   logic clk = 1'b0;
   logic rst_n, ce, rd, wr_s, alarm, conv, wait_r, act;
   logic [7:0] addr, seed;
   logic [31:0] wd, rdata;
   logic [2:0] sel, mv;
   logic [4:0] ic;
   mcs_policy_t pol;
   wire lclk, lsel_n, lsdi;
   int mismatches, n_tests, cyc;
   logic [31:0] expq[$];
   logic [7:0] idx[7] = '{MCS_IDX_STATUS, MCS_IDX_MANUAL, MCS_IDX_LAUNCH,
      MCS_IDX_HALT, MCS_IDX_INLINE, MCS_IDX_ENABLES, 8'h55};

   mcs_seq_ctrl u_mcs_seq_ctrl (.core_clk_in(clk), .reset_n_in(rst_n),
      .clk_en_in(ce), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_r), .alarm_pin_in(alarm),
      .conv_done_in(conv), .link_clk_in(lclk), .link_sel_n_in(lsel_n),
      .link_sdi_in(lsdi), .channel_sel_out(sel), .scan_active_out(act),
      .scan_policy_out(pol), .inline_choice_out(ic));
   mcs_link_host u_mcs_link_host (.link_clk_out(lclk),
      .link_sel_n_out(lsel_n), .link_sdi_out(lsdi));

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard: far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // Read data is due at the edge where waitrequest is seen low
   always @(posedge clk) begin
      if (rd === 1'b1 && wait_r === 1'b0) begin
         chk(rdata, expq.pop_front());
      end
   end

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= {24'h0, d};
      wr_s <= w;
      rd <= !w;
      // Only the hang guard ends a wait that never completes
      do begin
         @(posedge clk);
      end while (wait_r !== 1'b0);
      wr_s <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic br(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   // Port state compare after a settling wait, bounded poll
   task automatic po(input logic [4:0] i, input logic a, input logic [1:0] p,
                     input logic [2:0] s);
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      while ({ic, act, pol, sel} !== {i, a, p, s} && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk({21'h0, ic, act, pol, sel}, {21'h0, i, a, p, s});
   endtask

   task automatic pulse;
      @(posedge clk);
      conv <= 1'b1;
      @(posedge clk);
      conv <= 1'b0;
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      rd = 1'b0;
      wr_s = 1'b0;
      alarm = 1'b0;
      conv = 1'b0;
      addr = 8'h00;
      wd = 32'h0;
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      seed = 8'h2C;
      mv = 3'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (idx[k]) br(idx[k], 32'h0);
      done("reset");
      repeat (4) begin
         seed = lfsr(seed);
         bw(MCS_IDX_MANUAL, seed);
         mv = seed[2:0];
         br(MCS_IDX_MANUAL, {29'h0, mv});
         po(5'h00, 1'b0, MCS_POL_MANUAL, mv);
      end
      done("manual");
      // Alarm level random per mode; error only for auto with no inputs
      for (int p = 0; p < 4; p++) begin
         seed = lfsr(seed);
         alarm <= seed[0];
         bw(MCS_IDX_STATUS, p[7:0]);
         br(MCS_IDX_STATUS, {28'h0, seed[0], p == 2, p[1:0]});
      end
      done("status");
      bw(MCS_IDX_LAUNCH, 8'h01);
      po(5'h00, 1'b1, MCS_POL_CUSTOM, mv);
      bw(MCS_IDX_HALT, 8'h01);
      po(5'h00, 1'b0, MCS_POL_CUSTOM, mv);
      done("custom");
      bw(MCS_IDX_ENABLES, 8'h24);
      br(MCS_IDX_ENABLES, 32'h24);
      bw(MCS_IDX_STATUS, 8'h02);
      br(MCS_IDX_STATUS, {28'h0, alarm, 3'b010});
      bw(MCS_IDX_LAUNCH, 8'h00);
      po(5'h00, 1'b0, MCS_POL_AUTO, mv);
      bw(MCS_IDX_LAUNCH, 8'h01);
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h2);
      br(MCS_IDX_LAUNCH, 32'h0);
      // A step that comes while the clock enable is low must be lost
      ce <= 1'b0;
      pulse();
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h2);
      ce <= 1'b1;
      pulse();
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h5);
      bw(MCS_IDX_LAUNCH, 8'h00);
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h5);
      bw(MCS_IDX_HALT, 8'h00);
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h5);
      pulse();
      po(5'h00, 1'b0, MCS_POL_AUTO, mv);
      done("auto");
      bw(MCS_IDX_LAUNCH, 8'h01);
      po(5'h00, 1'b1, MCS_POL_AUTO, 3'h2);
      seed = lfsr(seed);
      mv = seed[2:0];
      bw(MCS_IDX_MANUAL, seed);
      po(5'h00, 1'b0, MCS_POL_MANUAL, mv);
      br(MCS_IDX_STATUS, {28'h0, alarm, 3'b000});
      bw(MCS_IDX_LAUNCH, 8'h01);
      po(5'h00, 1'b0, MCS_POL_MANUAL, mv);
      done("abort");
      bw(MCS_IDX_INLINE, 8'h01);
      br(MCS_IDX_INLINE, 32'h1);
      bw(MCS_IDX_STATUS, 8'h01);
      bw(MCS_IDX_LAUNCH, 8'h01);
      po(5'h00, 1'b0, MCS_POL_INLINE, 3'h0);
      u_mcs_link_host.send(5'h16);
      po(5'h16, 1'b0, MCS_POL_INLINE, 3'h6);
      bw(MCS_IDX_INLINE, 8'h00);
      u_mcs_link_host.send(5'h09);
      po(5'h16, 1'b0, MCS_POL_INLINE, mv);
      br(MCS_IDX_INLINE, 32'h0);
      done("inline");
      wrap_up();
   end
endmodule // mux_channel_sequencer_ctrl_test

/* verilog/mcs_pkg.sv */
/*
 * Constants and types shared by the mux channel sequencer control block.
 * Assumes registers sit on an Avalon-MM slave with word addressing, one
 * 8-bit register in the low byte of each 32-bit word.
 */
package mcs_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] MCS_IDX_STATUS = 8'h1C;
   localparam logic [7:0] MCS_IDX_MANUAL = 8'h1D;
   localparam logic [7:0] MCS_IDX_LAUNCH = 8'h1E;
   localparam logic [7:0] MCS_IDX_HALT = 8'h1F;
   localparam logic [7:0] MCS_IDX_INLINE = 8'h2A;
   localparam logic [7:0] MCS_IDX_ENABLES = 8'h80;

   // Field positions
   localparam int MCS_POLICY_LSB = 0;
   localparam int MCS_ERR_BIT = 2;
   localparam int MCS_ALARM_BIT = 3;
   localparam int MCS_GO_BIT = 0;
   localparam int MCS_INL_EN_BIT = 0;

   // Reset values
   localparam logic [2:0] MCS_RST_MANUAL = 3'h0;
   localparam logic MCS_RST_INL_EN = 1'h0;
   localparam logic [7:0] MCS_RST_ENABLES = 8'h00;
   localparam logic [4:0] MCS_RST_CHOICE = 5'h00;
   localparam logic [31:0] MCS_RD_NONE = 32'h0000_0000;

   // Sequencing policy encoding
   typedef enum logic [1:0] {
      MCS_POL_MANUAL = 2'b00,
      MCS_POL_INLINE = 2'b01,
      MCS_POL_AUTO = 2'b10,
      MCS_POL_CUSTOM = 2'b11
   } mcs_policy_t;

   // Scan sequence state
   typedef enum logic {
      MCS_SEQ_IDLE = 1'b0,
      MCS_SEQ_RUN = 1'b1
   } mcs_seq_t;

endpackage

/* verilog/mcs_seq_ctrl.sv */
/*
 * Control and status registers of the input mux channel sequencer, with
 * the scan stepper and the serial inline channel capture.
 * Assumes an Avalon-MM master on core_clk_in, a serial link clocked by
 * link_clk_in and framed by link_sel_n_in, and a same-domain pulse
 * conv_done_in at the end of each conversion.
 */
// Notes on behaviour
// - Policy field: manual, inline, auto, custom
// - Alarm and error flags read independently
// - Three-bit manual index selects input directly
// - Manual register upper bits read zero
// - Manual write aborts running sequence, sets manual
// - Launch bit starts scan in custom, and in auto only if an input is enabled
// - Launch zero write has no effect
// - Launch and halt ignored in manual/inline
// - Halt bit stops scan; zero does nothing
// - Enabled inline takes first five serial bits
// - Inline disabled at zero; upper bits zero
// - Bit n of enables includes input n
// - All scan enables clear at reset
// - Alarm flag follows alarm pin level
// - Error flag set on bad configuration
module mcs_seq_ctrl #(
   parameter int NUM_INPUTS = 8,
   parameter int INLINE_BITS = 5
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic alarm_pin_in,
   input wire logic conv_done_in,
   input wire logic link_clk_in,
   input wire logic link_sel_n_in,
   input wire logic link_sdi_in,
   output logic [2:0] channel_sel_out,
   output logic scan_active_out,
   output mcs_pkg::mcs_policy_t scan_policy_out,
   output logic [4:0] inline_choice_out
);
   import mcs_pkg::*;

   // The 3-bit index and 8-bit enable register fix these sizes
   generate
      if (NUM_INPUTS != 8 || INLINE_BITS != 5) begin : g_bad_param
         $error("mcs_seq_ctrl supports 8 inputs and 5 inline bits only");
      end
   endgenerate

   mcs_policy_t policy_r;
   mcs_seq_t seq_r;
   logic [2:0] manual_idx_r;
   logic inline_en_r;
   logic [7:0] enables_r;
   logic [2:0] ptr_r;
   logic [2:0] chan_nxt;
   logic wait_r;
   logic [31:0] rdata_nxt;
   logic alarm_s1_r, alarm_s2_r;
   logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
   logic [2:0] link_cnt_r;
   logic [4:0] link_shift_r;
   logic [4:0] link_word_r;
   logic link_tgl_r = 1'b0; // Link side has no reset; start level is fixed
   logic [4:0] inline_choice_r;
   logic wr_go, rd_go, man_wr, launch_go, halt_go, seq_mode, cfg_err;
   logic inline_ev;
   logic [3:0] first_hit, step_hit;

   // Next enabled input above 'after'; bit 3 flags a hit
   function automatic logic [3:0] mcs_next(input logic [7:0] en,
                                          input int after);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (en[i] && i > after) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   // Bus access completes on the cycle waitrequest is low
   assign wr_go = clk_en_in && avs_write_in && !wait_r;
   assign rd_go = clk_en_in && avs_read_in && !wait_r;
   assign man_wr = wr_go && avs_address_in == MCS_IDX_MANUAL;
   assign seq_mode = policy_r == MCS_POL_AUTO ||
                     policy_r == MCS_POL_CUSTOM;
   // Only bit 0 counts; other strobe bits are dropped
   assign launch_go = wr_go && avs_address_in == MCS_IDX_LAUNCH &&
                      avs_writedata_in[MCS_GO_BIT] && seq_mode;
   assign halt_go = wr_go && avs_address_in == MCS_IDX_HALT &&
                    avs_writedata_in[MCS_GO_BIT] && seq_mode;
   // Auto scan with nothing enabled cannot run, so flag it
   assign cfg_err = policy_r == MCS_POL_AUTO &&
                    enables_r == MCS_RST_ENABLES;
   assign first_hit = mcs_next(enables_r, -1);
   assign step_hit = mcs_next(enables_r, int'(ptr_r));

   // Alarm pin is asynchronous: two flops before use
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         alarm_s1_r <= 1'b0;
         alarm_s2_r <= 1'b0;
      end else if (clk_en_in) begin
         alarm_s1_r <= alarm_pin_in;
         alarm_s2_r <= alarm_s1_r;
      end
   end

   // Waitrequest: one wait cycle, then a single ready cycle
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         wait_r <= 1'b1;
      end else if (clk_en_in) begin
         wait_r <= !(wait_r && (avs_read_in || avs_write_in));
      end
   end

   // Read mux; unmapped and strobe registers read zero
   always_comb begin
      rdata_nxt = MCS_RD_NONE;
      unique case (avs_address_in)
         MCS_IDX_STATUS: begin
            rdata_nxt[MCS_POLICY_LSB +: 2] = policy_r;
            rdata_nxt[MCS_ERR_BIT] = cfg_err;
            rdata_nxt[MCS_ALARM_BIT] = alarm_s2_r;
         end
         MCS_IDX_MANUAL: rdata_nxt[2:0] = manual_idx_r;
         MCS_IDX_INLINE: rdata_nxt[MCS_INL_EN_BIT] = inline_en_r;
         MCS_IDX_ENABLES: rdata_nxt[7:0] = enables_r;
         default: rdata_nxt = MCS_RD_NONE;
      endcase
   end

   // Read data loaded in the wait cycle, stable in the ready cycle
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         avs_readdata_out <= MCS_RD_NONE;
      end else if (clk_en_in && wait_r && avs_read_in) begin
         avs_readdata_out <= rdata_nxt;
      end
   end

   // Policy field; a manual select write during a running scan forces manual
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         policy_r <= MCS_POL_MANUAL;
      end else if (man_wr && seq_r == MCS_SEQ_RUN) begin
         policy_r <= MCS_POL_MANUAL;
      end else if (wr_go && avs_address_in == MCS_IDX_STATUS) begin
         policy_r <= mcs_policy_t'(avs_writedata_in[1:0]);
      end
   end

   // Plain configuration registers; reserved bits dropped
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         manual_idx_r <= MCS_RST_MANUAL;
         inline_en_r <= MCS_RST_INL_EN;
         enables_r <= MCS_RST_ENABLES;
      end else if (wr_go) begin
         if (avs_address_in == MCS_IDX_MANUAL) begin
            manual_idx_r <= avs_writedata_in[2:0];
         end
         if (avs_address_in == MCS_IDX_INLINE) begin
            inline_en_r <= avs_writedata_in[MCS_INL_EN_BIT];
         end
         if (avs_address_in == MCS_IDX_ENABLES) begin
            enables_r <= avs_writedata_in[7:0];
         end
      end
   end

   // Scan stepper; abort and halt outrank launch and stepping
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         seq_r <= MCS_SEQ_IDLE;
         ptr_r <= 3'h0;
      end else if (clk_en_in) begin
         if (man_wr) begin
            seq_r <= MCS_SEQ_IDLE;
         end else if (halt_go) begin
            seq_r <= MCS_SEQ_IDLE;
         end else if (launch_go) begin
            if (policy_r == MCS_POL_CUSTOM) begin
               seq_r <= MCS_SEQ_RUN;
            end else if (first_hit[3]) begin
               seq_r <= MCS_SEQ_RUN;
               ptr_r <= first_hit[2:0];
            end
         end else if (!seq_mode) begin
            seq_r <= MCS_SEQ_IDLE;
         end else if (seq_r == MCS_SEQ_RUN && conv_done_in &&
                      policy_r == MCS_POL_AUTO) begin
            // Ends after the last enabled input; no repeat here
            if (step_hit[3]) begin
               ptr_r <= step_hit[2:0];
            end else begin
               seq_r <= MCS_SEQ_IDLE;
            end
         end
      end
   end

   // Link side: bit counter cleared by the frame's own select
   always_ff @(posedge link_clk_in or posedge link_sel_n_in) begin
      if (link_sel_n_in) begin
         link_cnt_r <= 3'h0;
      end else if (link_cnt_r != 3'(INLINE_BITS)) begin
         link_cnt_r <= link_cnt_r + 3'h1;
      end
   end

   // First five serial bits, MSB first; toggle marks a new word
   always_ff @(posedge link_clk_in) begin
      if (!link_sel_n_in && link_cnt_r != 3'(INLINE_BITS)) begin
         link_shift_r <= {link_shift_r[3:0], link_sdi_in};
         if (link_cnt_r == 3'(INLINE_BITS - 1)) begin
            link_word_r <= {link_shift_r[3:0], link_sdi_in};
            link_tgl_r <= !link_tgl_r;
         end
      end
   end

   // Toggle crossing; the word is held far longer than the sync delay
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
      end else if (clk_en_in) begin
         tgl_s1_r <= link_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   assign inline_ev = clk_en_in && (tgl_s2_r ^ tgl_s3_r);

   // Inline choice only taken while enabled
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         inline_choice_r <= MCS_RST_CHOICE;
      end else if (inline_ev && inline_en_r) begin
         inline_choice_r <= link_word_r;
      end
   end

   // Channel driven to the mux for the next conversion
   always_comb begin
      chan_nxt = manual_idx_r;
      if (policy_r == MCS_POL_INLINE && inline_en_r) begin
         chan_nxt = inline_choice_r[2:0];
      end else if (seq_r == MCS_SEQ_RUN &&
                   policy_r == MCS_POL_AUTO) begin
         chan_nxt = ptr_r;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         channel_sel_out <= MCS_RST_MANUAL;
      end else if (clk_en_in) begin
         channel_sel_out <= chan_nxt;
      end
   end

   assign avs_waitrequest_out = wait_r;
   assign scan_active_out = seq_r;
   assign scan_policy_out = policy_r;
   assign inline_choice_out = inline_choice_r;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_rd(logic [7:0] idx);
      avs_read_in && !avs_waitrequest_out && avs_address_in == idx;
   endsequence

   sequence s_wr(logic [7:0] idx);
      avs_write_in && !avs_waitrequest_out && avs_address_in == idx &&
      clk_en_in;
   endsequence

   AST_POLICY_READ: assert property (
      s_rd(MCS_IDX_STATUS) |-> avs_readdata_out[1:0] == $past(policy_r))
      else $error("status read policy mismatch");

   AST_ALARM_FLAG: assert property (
      s_rd(MCS_IDX_STATUS) |->
      avs_readdata_out[MCS_ALARM_BIT] == $past(alarm_s2_r))
      else $error("alarm flag does not follow pin");

   AST_ERR_FLAG: assert property (
      s_rd(MCS_IDX_STATUS) |->
      avs_readdata_out[MCS_ERR_BIT] == $past(cfg_err))
      else $error("error flag wrong");

   AST_MANUAL_HIGH: assert property (
      s_rd(MCS_IDX_MANUAL) |-> avs_readdata_out[7:3] == 5'h00 &&
      avs_readdata_out[2:0] == $past(manual_idx_r))
      else $error("manual select readback wrong");

   AST_STROBE_ZERO: assert property (
      s_rd(MCS_IDX_LAUNCH) or s_rd(MCS_IDX_HALT) |->
      avs_readdata_out == MCS_RD_NONE)
      else $error("strobe register read nonzero");

   AST_MANUAL_ABORT: assert property (
      s_wr(MCS_IDX_MANUAL) ##0 scan_active_out |=>
      !scan_active_out && policy_r == MCS_POL_MANUAL)
      else $error("manual write did not abort scan");

   AST_LAUNCH: assert property (
      s_wr(MCS_IDX_LAUNCH) ##0 avs_writedata_in[0] &&
      policy_r == MCS_POL_AUTO && enables_r != 8'h00 |=>
      scan_active_out ##1 channel_sel_out == $past(ptr_r))
      else $error("launch did not start scan");

   AST_LAUNCH_ZERO: assert property (
      s_wr(MCS_IDX_LAUNCH) ##0 !avs_writedata_in[0] && scan_active_out &&
      !conv_done_in && seq_mode |=> scan_active_out)
      else $error("launch zero stopped scan");

   AST_PASSIVE: assert property (
      !seq_mode && clk_en_in |=> !scan_active_out [*2])
      else $error("scan runs in manual or inline policy");

   AST_HALT: assert property (
      s_wr(MCS_IDX_HALT) ##0 avs_writedata_in[0] && seq_mode |=>
      !scan_active_out)
      else $error("halt did not stop scan");

   AST_INLINE_OFF: assert property (
      !inline_en_r |=> $stable(inline_choice_r))
      else $error("inline choice moved while disabled");

   AST_INLINE_TAKE: assert property (
      inline_ev && inline_en_r |=> inline_choice_out == $past(link_word_r))
      else $error("inline choice not taken");

   AST_ENABLES_RESET: assert property (
      disable iff (1'b0) !reset_n_in |=> enables_r == 8'h00)
      else $error("scan enables not cleared by reset");

   AST_MANUAL_CHAN: assert property (
      policy_r == MCS_POL_MANUAL && clk_en_in |=>
      channel_sel_out == $past(manual_idx_r))
      else $error("manual index not on mux select");

   AST_WAIT_ONE: assert property (
      clk_en_in && avs_waitrequest_out && (avs_read_in || avs_write_in)
      |=> !avs_waitrequest_out)
      else $error("waitrequest held too long");

endmodule // mcs_seq_ctrl
